// >>> logic/sfp_map.svh
`ifndef SFP_MAP_SVH
`define SFP_MAP_SVH
// command codes
`define SFP_OP_WR_EN      8'h06
`define SFP_OP_WR_DIS     8'h04
`define SFP_OP_RD_ST_LO   8'h05
`define SFP_OP_RD_ST_HI   8'h35
`define SFP_OP_ST_WR      8'h01
`define SFP_OP_READ       8'h03
`define SFP_OP_FAST       8'h0B
`define SFP_OP_DUAL_OUT   8'h3B
`define SFP_OP_DUAL_IO    8'hBB
`define SFP_OP_QUAD_OUT   8'h6B
`define SFP_OP_QUAD_IO    8'hEB
`define SFP_OP_PROG       8'h02
`define SFP_OP_SECT_ERASE 8'h20
`define SFP_OP_BLK_ERASE  8'hD8
`define SFP_OP_CHIP_ERASE 8'hC7
`define SFP_OP_DPD        8'hB9
`define SFP_OP_DPD_EXIT   8'hAB
// dummy clocks after the address
`define SFP_DUMMY_FAST    4'h8
`define SFP_DUMMY_DUAL_IO 4'h4
`define SFP_DUMMY_QUAD_IO 4'h6
// frame lengths in bits
`define SFP_BITS_CMD      16'h0008
`define SFP_BITS_ADDR     16'h0020
`define SFP_BITS_ST1      16'h0010
`define SFP_BITS_ST2      16'h0018
// non-volatile status reset value
`define SFP_NV_RESET      8'h00
// array geometry
`define SFP_ARRAY_TOP     17'h1FFFF
`define SFP_HALF          17'h10000
`define SFP_PAGE_MASK     17'h000FF
`define SFP_SECT_MASK     17'h00FFF
`define SFP_BLK_MASK      17'h0FFFF
`define SFP_SIZE_4K       17'h01000
`define SFP_SIZE_8K       17'h02000
`define SFP_SIZE_16K      17'h04000
`define SFP_SIZE_32K      17'h08000
// internal operation time
`define SFP_CLK_NS        4
`define SFP_BUSY_NS       700000
`endif

// >>> logic/sfp_pkg.sv
package sfp_pkg;
  typedef enum logic [2:0] {
    LS_CMD   = 3'b000,
    LS_ADDR  = 3'b001,
    LS_DUMMY = 3'b010,
    LS_DATA  = 3'b011,
    LS_IGN   = 3'b100
  } sfp_lstate_t;
  typedef enum logic [1:0] {
    OP_PROG  = 2'b00,
    OP_SECT  = 2'b01,
    OP_BLK   = 2'b10,
    OP_CHIP  = 2'b11
  } sfp_op_t;
  typedef struct packed {
    sfp_op_t     op;
    logic [16:0] addr;
  } sfp_arr_req_t;
  typedef struct packed {
    logic       qe;
    logic       status_lock_bit_one;
    logic       status_lock_bit_zero;
    logic       sec;
    logic       tb;
    logic [2:0] bp;
  } sfp_nv_t;
  typedef struct packed {
    logic [2:0] aw;
    logic [2:0] dw;
    logic [3:0] dummy;
    logic       has_addr;
    logic       is_read;
    logic       quad;
    logic [1:0] src;
  } sfp_dec_t;
endpackage

// >>> logic/sfp_sync.sv
`timescale 1ns/1ps
module sfp_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // level in and out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta <= RST;
      q    <= RST;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule

// >>> logic/sfp_prot.sv
`timescale 1ns/1ps
`include "sfp_map.svh"
module sfp_prot (
  // protect fields
  input  wire logic        sec,
  input  wire logic        tb,
  input  wire logic [2:0]  bp,
  // protected window
  output logic             prot_en,
  output logic      [16:0] prot_lo,
  output logic      [16:0] prot_hi
);
  logic [16:0] size;

  always_comb
  begin
    size    = `SFP_HALF;
    prot_en = 1'b1;
    if (!sec)
    begin
      prot_en = bp[1] | bp[0];
      if (bp[1])
        size = '0;
    end
    else
    begin
      case (bp)
        3'h0:    prot_en = 1'b0;
        3'h1:    size = `SFP_SIZE_4K;
        3'h2:    size = `SFP_SIZE_8K;
        3'h3:    size = `SFP_SIZE_16K;
        3'h7:    size = '0;
        default: size = `SFP_SIZE_32K;
      endcase
    end
    // size zero stands for the whole array
    if (size == '0)
    begin
      prot_lo = '0;
      prot_hi = `SFP_ARRAY_TOP;
    end
    else if (tb)
    begin
      prot_lo = '0;
      prot_hi = size - 17'h00001;
    end
    else
    begin
      prot_lo = `SFP_ARRAY_TOP - size + 17'h00001;
      prot_hi = `SFP_ARRAY_TOP;
    end
  end
endmodule

// >>> logic/sfp_top.sv
`timescale 1ns/1ps
`include "sfp_map.svh"
// How it works
// - works with host clock mode 0 or 3, idle clock level set by host
// - inputs sampled on rising serial clock, outputs changed on falling clock
// - dual reads drive lines zero and one, two bits per clock; only dual I/O also takes the address on both
// - quad reads add lines two and three, four bits per clock
// - quad commands accepted only while the quad enable bit is set
// - pause freezes the link, internal write or erase keeps running
// - pause needs select low, starts on pause low only while clock low
// - pause ends on pause high only while clock low, else waits
// - during pause the output floats and clock and input are ignored
// - select rising during pause resets link logic, bits clocked before the pause still execute at frame end
// - write enable command sets the write enable latch
// - latch clears at power-up, write disable and end of write or erase
// - protected region readable, never modified
// - hardware mode: write protect low locks protect and lock bits
// - in deep power-down only the release command is obeyed
// - block granularity: 00 none, x01 one half by top/bottom, 1x all
// - sector granularity: 4K, 8K, 16K, 32K at top or bottom end
// - sector granularity: 000 none, 110 32K, 111 whole array
// - array is two 64K blocks of sixteen 4K sectors each
// - lock bits: 00 free, 01 pin lock, 10 or 11 until power cycle
// - write class commands need whole bytes or are rejected
// - quad enable turns protect and pause pins into data lines
module sfp_top #(
  parameter int BUSY_CYCLES = `SFP_BUSY_NS / `SFP_CLK_NS
) (
  // system clock and reset
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // serial link
  input  wire logic                 sclk,
  input  wire logic                 cs_n,
  input  wire logic                 data_line_zero_in,
  output logic                      data_line_zero_out,
  output logic                      data_line_zero_oe,
  input  wire logic                 data_line_one_in,
  output logic                      data_line_one_out,
  output logic                      data_line_one_oe,
  input  wire logic                 data_line_two_in,
  output logic                      data_line_two_out,
  output logic                      data_line_two_oe,
  input  wire logic                 data_line_three_in,
  output logic                      data_line_three_out,
  output logic                      data_line_three_oe,
  // array read port, serial clock domain
  output logic               [16:0] rd_addr,
  input  wire logic          [7:0]  rd_data,
  // array requests, system clock domain
  output logic                      array_req,
  output sfp_pkg::sfp_arr_req_t     array_cmd,
  // status
  output logic               [15:0] status_word,
  output logic                      deep_power_down
);
  import sfp_pkg::*;

  function automatic sfp_dec_t decode(input logic [7:0] op);
    sfp_dec_t d;
    d = '{aw: 3'h1, dw: 3'h1, dummy: 4'h0, has_addr: 1'b0,
          is_read: 1'b0, quad: 1'b0, src: 2'h0};
    case (op)
      `SFP_OP_RD_ST_LO: d.is_read = 1'b1;
      `SFP_OP_RD_ST_HI: d.is_read = 1'b1;
      `SFP_OP_READ:     d.has_addr = 1'b1;
      `SFP_OP_FAST:     d.dummy = `SFP_DUMMY_FAST;
      `SFP_OP_DUAL_OUT: d.dummy = `SFP_DUMMY_FAST;
      `SFP_OP_DUAL_IO:  d.dummy = `SFP_DUMMY_DUAL_IO;
      `SFP_OP_QUAD_OUT: d.dummy = `SFP_DUMMY_FAST;
      `SFP_OP_QUAD_IO:  d.dummy = `SFP_DUMMY_QUAD_IO;
      `SFP_OP_PROG:       d.has_addr = 1'b1;
      `SFP_OP_SECT_ERASE: d.has_addr = 1'b1;
      `SFP_OP_BLK_ERASE:  d.has_addr = 1'b1;
      default: ;
    endcase
    case (op)
      `SFP_OP_RD_ST_LO: d.src = 2'h1;
      `SFP_OP_RD_ST_HI: d.src = 2'h2;
      `SFP_OP_READ, `SFP_OP_FAST, `SFP_OP_DUAL_OUT, `SFP_OP_DUAL_IO,
      `SFP_OP_QUAD_OUT, `SFP_OP_QUAD_IO:
      begin
        d.has_addr = 1'b1;
        d.is_read  = 1'b1;
      end
      default: ;
    endcase
    if (op == `SFP_OP_DUAL_OUT || op == `SFP_OP_DUAL_IO)
      d.dw = 3'h2;
    if (op == `SFP_OP_QUAD_OUT || op == `SFP_OP_QUAD_IO)
    begin
      d.dw   = 3'h4;
      d.quad = 1'b1;
    end
    if (op == `SFP_OP_DUAL_IO)
      d.aw = 3'h2;
    if (op == `SFP_OP_QUAD_IO)
      d.aw = 3'h4;
    return d;
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // system clock side: pin synchronisers and pause tracking

  logic         sclk_s;
  logic         cs_s;
  logic         hold_s;
  logic         wp_s;
  logic         cs_q;
  logic         hold_active;
  sfp_nv_t      nv;
  logic         write_enable_latch;
  logic         dpd;
  logic         go_busy;
  logic [19:0]  busy_cnt;
  logic         wip;
  logic         busy_done;

  sfp_sync #(
    .W   (4),
    .RST (4'h7)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .d       ({sclk, cs_n, data_line_three_in, data_line_two_in}),
    .q       ({sclk_s, cs_s, hold_s, wp_s})
  );

  // pause only moves while the serial clock is low, so it is steady at
  // every rising edge that the link logic takes
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      hold_active <= 1'b0;
    else if (cs_s || nv.qe)
      hold_active <= 1'b0;
    else if (!sclk_s)
      hold_active <= !hold_s;
  end

  //////////////////////////////////////////////////////////////////////////
  // serial clock side: frame decoding

  logic [15:0]  st_meta;
  logic [15:0]  st_link;
  logic [1:0]   flag_meta;
  logic [1:0]   flag_link;
  logic         qe_link;
  logic         dpd_link;
  sfp_lstate_t  lstate;
  logic         first;
  logic [4:0]   slot;
  sfp_dec_t     dec_q;
  sfp_dec_t     dec_now;
  logic [7:0]   cmd_byte;
  logic [7:0]   opcode;
  logic [15:0]  bit_cnt;
  logic [31:0]  sh;
  logic [23:0]  addr;
  logic [3:0]   lines;
  logic [4:0]   addr_last;
  logic [4:0]   byte_last;

  assign lines    = {data_line_three_in, data_line_two_in,
                     data_line_one_in, data_line_zero_in};
  assign cmd_byte = {opcode[6:0], data_line_zero_in};
  assign dec_now  = decode(cmd_byte);
  assign qe_link  = flag_link[1];
  assign dpd_link = flag_link[0];
  assign rd_addr  = addr[16:0];

  always_comb
  begin
    case (dec_q.aw)
      3'h4:    addr_last = 5'h05;
      3'h2:    addr_last = 5'h0B;
      default: addr_last = 5'h17;
    endcase
    case (dec_q.dw)
      3'h4:    byte_last = 5'h01;
      3'h2:    byte_last = 5'h03;
      default: byte_last = 5'h07;
    endcase
  end

  // mode flags only change between frames, the busy and latch bits at any time; two stages here
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_meta   <= '0;
      st_link   <= '0;
      flag_meta <= '0;
      flag_link <= '0;
    end
    else
    begin
      st_meta   <= status_word;
      st_link   <= st_meta;
      flag_meta <= {nv.qe, dpd};
      flag_link <= flag_meta;
    end
  end

  // phase state: select high clears it, also mid-pause
  always_ff @(posedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      lstate <= LS_CMD;
      slot   <= '0;
      first  <= 1'b1;
      dec_q  <= '0;
    end
    else if (!hold_active)
    begin
      first <= 1'b0;
      slot  <= slot + 5'h01;
      case (lstate)
        LS_CMD:
        begin
          if (slot == 5'h07)
          begin
            slot  <= '0;
            dec_q <= dec_now;
            if (dpd_link && cmd_byte != `SFP_OP_DPD_EXIT)
              lstate <= LS_IGN;
            else if (dec_now.quad && !qe_link)
              lstate <= LS_IGN;
            else if (dec_now.has_addr)
              lstate <= LS_ADDR;
            else if (dec_now.is_read)
              lstate <= LS_DATA;
            else
              lstate <= LS_IGN;
          end
        end
        LS_ADDR:
        begin
          if (slot == addr_last)
          begin
            slot <= '0;
            if (!dec_q.is_read)
              lstate <= LS_IGN;
            else if (dec_q.dummy != 4'h0)
              lstate <= LS_DUMMY;
            else
              lstate <= LS_DATA;
          end
        end
        LS_DUMMY:
        begin
          if (slot == {1'b0, dec_q.dummy - 4'h1})
          begin
            slot   <= '0;
            lstate <= LS_DATA;
          end
        end
        LS_DATA:
        begin
          if (slot == byte_last)
            slot <= '0;
        end
        LS_IGN:  slot <= '0;
        default: lstate <= LS_IGN;
      endcase
    end
  end

  // frame record: kept past the frame end so the system side can read it
  always_ff @(posedge sclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      opcode  <= '0;
      bit_cnt <= '0;
      sh      <= '0;
      addr    <= '0;
    end
    else if (!cs_n && !hold_active)
    begin
      if (first)
        bit_cnt <= 16'h0001;
      else if (bit_cnt != 16'hFFFF)
        bit_cnt <= bit_cnt + 16'h0001;
      sh <= {sh[30:0], data_line_zero_in};
      if (lstate == LS_CMD)
        opcode <= cmd_byte;
      if (lstate == LS_ADDR)
      begin
        case (dec_q.aw)
          3'h4:    addr <= {addr[19:0], lines};
          3'h2:    addr <= {addr[21:0], lines[1:0]};
          default: addr <= {addr[22:0], lines[0]};
        endcase
      end
      if (lstate == LS_DATA && slot == byte_last && dec_q.src == 2'h0)
        addr <= addr + 24'h000001;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // serial clock side: output on falling edges

  logic [7:0]   ob;
  logic [3:0]   out_bits;
  logic [3:0]   out_en;

  always_comb
  begin
    case (dec_q.src)
      2'h1:    ob = st_link[7:0];
      2'h2:    ob = st_link[15:8];
      default: ob = rd_data;
    endcase
  end

  always_ff @(negedge sclk or posedge cs_n)
  begin
    if (cs_n)
    begin
      out_bits <= '0;
      out_en   <= '0;
    end
    else if (!hold_active)
    begin
      if (lstate == LS_DATA)
      begin
        case (dec_q.dw)
          3'h4:
          begin
            out_bits <= slot[0] ? ob[3:0] : ob[7:4];
            out_en   <= 4'hF;
          end
          3'h2:
          begin
            out_bits <= {2'h0, ob[3'h6 - {slot[1:0], 1'b0} +: 2]};
            out_en   <= 4'h3;
          end
          default:
          begin
            out_bits <= {2'h0, ob[3'h7 - slot[2:0]], 1'b0};
            out_en   <= 4'h2;
          end
        endcase
      end
      else
        out_en <= '0;
    end
  end

  assign data_line_zero_out  = out_bits[0];
  assign data_line_one_out   = out_bits[1];
  assign data_line_two_out   = out_bits[2];
  assign data_line_three_out = out_bits[3];
  // pause floats every driven line at once
  assign data_line_zero_oe   = out_en[0] & !hold_active;
  assign data_line_one_oe    = out_en[1] & !hold_active;
  assign data_line_two_oe    = out_en[2] & !hold_active;
  assign data_line_three_oe  = out_en[3] & !hold_active;

  //////////////////////////////////////////////////////////////////////////
  // system clock side: command execution at frame end

  logic         frame_end;
  logic         byte_ok;
  logic         wp_level;
  logic         sr_lock;
  logic         prot_en;
  logic [16:0]  prot_lo;
  logic [16:0]  prot_hi;
  logic [16:0]  t_lo;
  logic [16:0]  t_hi;
  logic         prot_hit;
  logic [7:0]   st_b1;
  logic         write_ok;

  sfp_prot u_prot (
    .sec     (nv.sec),
    .tb      (nv.tb),
    .bp      (nv.bp),
    .prot_en (prot_en),
    .prot_lo (prot_lo),
    .prot_hi (prot_hi)
  );

  assign frame_end = cs_s && !cs_q;
  assign byte_ok   = bit_cnt[2:0] == 3'h0;
  assign write_ok  = byte_ok && write_enable_latch && !wip;
  assign wp_level  = nv.qe | wp_s;
  assign sr_lock   = nv.status_lock_bit_one | (nv.status_lock_bit_zero & !wp_level);
  assign st_b1     = (bit_cnt == `SFP_BITS_ST1) ? sh[7:0] : sh[15:8];

  // target span of a program or erase: a page, sector or block, or the whole array for chip erase
  always_comb
  begin
    case (opcode)
      `SFP_OP_PROG:       t_lo = addr[16:0] & ~`SFP_PAGE_MASK;
      `SFP_OP_SECT_ERASE: t_lo = addr[16:0] & ~`SFP_SECT_MASK;
      `SFP_OP_BLK_ERASE:  t_lo = addr[16:0] & ~`SFP_BLK_MASK;
      default:            t_lo = '0;
    endcase
    case (opcode)
      `SFP_OP_PROG:       t_hi = t_lo | `SFP_PAGE_MASK;
      `SFP_OP_SECT_ERASE: t_hi = t_lo | `SFP_SECT_MASK;
      `SFP_OP_BLK_ERASE:  t_hi = t_lo | `SFP_BLK_MASK;
      default:            t_hi = `SFP_ARRAY_TOP;
    endcase
  end

  assign prot_hit = prot_en && !(t_hi < prot_lo || t_lo > prot_hi);

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cs_q      <= 1'b1;
      nv        <= `SFP_NV_RESET;
      write_enable_latch       <= 1'b0;
      dpd       <= 1'b0;
      go_busy   <= 1'b0;
      array_req <= 1'b0;
      array_cmd <= '0;
    end
    else
    begin
      cs_q      <= cs_s;
      go_busy   <= 1'b0;
      array_req <= 1'b0;
      if (busy_done)
        write_enable_latch <= 1'b0;
      if (frame_end && bit_cnt >= `SFP_BITS_CMD)
      begin
        if (dpd)
        begin
          if (opcode == `SFP_OP_DPD_EXIT)
            dpd <= 1'b0;
        end
        else
        begin
          case (opcode)
            `SFP_OP_WR_EN:
              if (bit_cnt == `SFP_BITS_CMD && !wip)
                write_enable_latch <= 1'b1;
            `SFP_OP_WR_DIS:
              if (bit_cnt == `SFP_BITS_CMD && !wip)
                write_enable_latch <= 1'b0;
            `SFP_OP_DPD:
              if (bit_cnt == `SFP_BITS_CMD && !wip)
                dpd <= 1'b1;
            `SFP_OP_ST_WR:
              if (write_ok && !sr_lock &&
                  (bit_cnt == `SFP_BITS_ST1 || bit_cnt == `SFP_BITS_ST2))
              begin
                {nv.status_lock_bit_zero, nv.sec, nv.tb, nv.bp} <= st_b1[7:2];
                if (bit_cnt == `SFP_BITS_ST2)
                  {nv.qe, nv.status_lock_bit_one} <= sh[1:0];
                go_busy <= 1'b1;
              end
            `SFP_OP_PROG, `SFP_OP_SECT_ERASE, `SFP_OP_BLK_ERASE,
            `SFP_OP_CHIP_ERASE:
              if (write_ok && bit_cnt == (opcode == `SFP_OP_CHIP_ERASE ?
                  `SFP_BITS_CMD : `SFP_BITS_ADDR) ||
                  write_ok && opcode == `SFP_OP_PROG && bit_cnt > `SFP_BITS_ADDR)
              begin
                if (prot_hit)
                  write_enable_latch <= 1'b0;
                else
                begin
                  go_busy   <= 1'b1;
                  array_req <= 1'b1;
                  array_cmd.addr <= t_lo;
                  case (opcode)
                    `SFP_OP_PROG:       array_cmd.op <= OP_PROG;
                    `SFP_OP_SECT_ERASE: array_cmd.op <= OP_SECT;
                    `SFP_OP_BLK_ERASE:  array_cmd.op <= OP_BLK;
                    default:            array_cmd.op <= OP_CHIP;
                  endcase
                end
              end
            default: ;
          endcase
        end
      end
    end
  end

  // internal operation timer runs on regardless of pause
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      busy_cnt <= '0;
    else if (go_busy)
      busy_cnt <= 20'(BUSY_CYCLES);
    else if (busy_cnt != '0)
      busy_cnt <= busy_cnt - 20'h00001;
  end

  assign wip             = busy_cnt != '0;
  assign busy_done       = busy_cnt == 20'h00001;
  assign deep_power_down = dpd;
  assign status_word     = {6'h00, nv.qe, nv.status_lock_bit_one, nv.status_lock_bit_zero, nv.sec, nv.tb,
                            nv.bp, write_enable_latch, wip};
endmodule

// >>> verification/sfp_top_assertions.sv
`timescale 1ns/1ps
module sfp_chk #(
  parameter int BUSY_CYCLES = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // serial link
  input wire logic        sclk,
  input wire logic        cs_n,
  input wire logic        data_line_three_in,
  input wire logic        data_line_one_out,
  input wire logic        data_line_one_oe,
  input wire logic        data_line_two_oe,
  input wire logic        data_line_three_oe,
  // system side
  input wire logic        array_req,
  input wire logic [15:0] status_word,
  input wire logic        deep_power_down
);
  logic [31:0] bcnt;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // wip length counter: a stuck busy flag would block every later write
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
      bcnt <= '0;
    else
      bcnt <= status_word[0] ? bcnt + 32'h1 : '0;
  sequence pause_held;
    (!cs_n && !status_word[9] && !data_line_three_in && !sclk) [*4];
  endsequence
  sequence clk_high_sel;
    (!cs_n && sclk) [*2];
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  a_req_one_pulse: assert property (array_req |=> !array_req)
    else $error("request longer than a pulse");
  a_req_sets_busy: assert property (array_req |-> ##[0:3] status_word[0])
    else $error("request without busy");
  a_done_clears_wel: assert property ($fell(status_word[0]) |-> ##[0:2] !status_word[1])
    else $error("latch kept after completion");
  a_sleep_no_req: assert property (deep_power_down |-> !array_req)
    else $error("request while asleep");
  a_idle_no_drive: assert property (cs_n && $past(cs_n) |-> !data_line_one_oe)
    else $error("driving while deselected");
  a_pause_float: assert property (pause_held |-> !data_line_one_oe)
    else $error("driving during pause");
  a_quad_off_quiet: assert property (!status_word[9] && !$past(status_word[9])
    |-> !data_line_two_oe && !data_line_three_oe)
    else $error("quad lines driven");
  a_out_on_fall: assert property (clk_high_sel |-> $stable(data_line_one_out))
    else $error("output moved while clock high");
  a_busy_bounded: assert property (bcnt <= BUSY_CYCLES + 8)
    else $error("busy too long");
endmodule
bind sfp_top sfp_chk #(.BUSY_CYCLES(BUSY_CYCLES)) sfp_chk_inst (.clk(clk), .sys_rst(sys_rst),
  .sclk(sclk), .cs_n(cs_n), .data_line_three_in(data_line_three_in),
  .data_line_one_out(data_line_one_out), .data_line_one_oe(data_line_one_oe),
  .data_line_two_oe(data_line_two_oe), .data_line_three_oe(data_line_three_oe),
  .array_req(array_req), .status_word(status_word), .deep_power_down(deep_power_down));

// >>> verification/sfp_hst.sv
`timescale 1ns/1ps
module sfp_hst (
  // host drive
  output logic      sclk,
  output logic      cs_n,
  output logic      line_zero,
  output logic      line_two,
  output logic      line_three,
  // device reply
  input  wire logic line_one
);
  logic [7:0] rx;
  // clock parked low between frames, protect and pause pins high
  initial {sclk, cs_n, line_zero, line_two, line_three} = 5'h0F;
  // mode 0: data set while clock low, reply taken at the rise
  task automatic bit_x(input logic b);
    line_zero = b;
    #62.5 sclk = 1'b1;
    rx = {rx[6:0], line_one};
    #62.5 sclk = 1'b0;
  endtask
  task automatic byte_x(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      bit_x(b[i]);
  endtask
  // a clock parked high (mode 3) falls here before the first bit
  task automatic start;
    cs_n = 1'b0;
    #62.5 sclk = 1'b0;
  endtask
  // long gap lets results cross into the system clock
  task automatic stop;
    cs_n = 1'b1;
    #500;
  endtask
endmodule

// >>> verification/sfp_top_test.sv
`timescale 1ns/1ps
module sfp_top_test;
  import sfp_pkg::*;
  logic               clk, sys_rst, o0, e0, o1, e1, o2, e2, o3, e3, array_req, deep_power_down;
  wire logic          sclk, cs_n, h0, h2, h3, l0, l1, l2, l3;
  logic        [16:0] rd_addr, a;
  logic        [15:0] status_word;
  sfp_arr_req_t       array_cmd;
  logic        [7:0]  lfsr, st;
  logic        [9:0]  tbl [6];
  int                 failures, n_checks, n_req, n;
  // undriven reply reads back inverted so a stale bit never passes
  assign l0 = e0 ? o0 : h0;
  assign l1 = e1 ? o1 : ~o1;
  assign l2 = e2 ? o2 : h2;
  assign l3 = e3 ? o3 : h3;
  sfp_hst sfp_hst_inst (.sclk(sclk), .cs_n(cs_n), .line_zero(h0), .line_two(h2),
    .line_three(h3), .line_one(l1));
  sfp_top #(.BUSY_CYCLES(20)) sfp_top_inst (.clk(clk), .sys_rst(sys_rst), .sclk(sclk),
    .cs_n(cs_n), .data_line_zero_in(l0), .data_line_zero_out(o0), .data_line_zero_oe(e0),
    .data_line_one_in(l1), .data_line_one_out(o1), .data_line_one_oe(e1),
    .data_line_two_in(l2), .data_line_two_out(o2), .data_line_two_oe(e2),
    .data_line_three_in(l3), .data_line_three_out(o3), .data_line_three_oe(e3),
    .rd_addr(rd_addr), .rd_data(rd_addr[7:0] ^ 8'h5A), .array_req(array_req),
    .array_cmd(array_cmd), .status_word(status_word), .deep_power_down(deep_power_down));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] nxt(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // f is sec, tb, bp
  function automatic logic prot(logic [4:0] f, logic [16:0] ad);
    logic [17:0] sz;
    if (!f[4])
      sz = f[1] ? 18'h20000 : f[0] ? 18'h10000 : 18'h00000;
    else if (f[2:0] == 3'h7)
      sz = 18'h20000;
    else if (f[2])
      sz = 18'h08000;
    else
      sz = (f[1:0] == 2'h0) ? 18'h00000 : 18'h00800 << f[1:0];
    return f[3] ? {1'b0, ad} < sz : {1'b0, ad} >= 18'h20000 - sz;
  endfunction
  task automatic chk(input string what, input logic [18:0] exp, input logic [18:0] got);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (failures == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wait_idle;
    int i;
    for (i = 0; i < 400 && status_word[0] !== 1'b0; i++)
      @(posedge clk);
    if (i == 400)
    begin
      failures++;
      final_report;
    end
  endtask
  task automatic xfer(input logic [7:0] q [$]);
    sfp_hst_inst.start;
    foreach (q[k])
      sfp_hst_inst.byte_x(q[k]);
    sfp_hst_inst.stop;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk)
    if (array_req === 1'b1)
      n_req <= n_req + 1;
  initial
  begin
    #300000;
    failures++;
    final_report;
  end
  initial
  begin
    sys_rst = 1'b1;
    lfsr = 8'h5B;
    a = '0;
    st = '0;
    tbl = '{10'h23F, 10'h23E, 10'h3C7, 10'h3C8, 10'h030, 10'h02F};
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clk);
    chk("status at reset", 0, status_word);
    xfer({8'h06});
    chk("wel set", 1, status_word[1]);
    xfer({8'h04});
    chk("wel off", 0, status_word[1]);
    sfp_hst_inst.start;
    sfp_hst_inst.byte_x(8'h06);
    sfp_hst_inst.bit_x(1'b0);
    sfp_hst_inst.stop;
    chk("nine clocks", 0, status_word[1]);
    xfer({8'hB9});
    chk("asleep", 1, deep_power_down);
    xfer({8'h06});
    chk("wel asleep", 0, status_word[1]);
    xfer({8'hAB});
    chk("awake", 0, deep_power_down);
    // boundary sectors first, then random patterns
    for (int i = 0; i < 16; i++)
    begin
      lfsr = nxt(lfsr);
      {st[6:2], a[16:12]} = (i < 6) ? tbl[i] : {lfsr[4:0], lfsr[7:3]};
      xfer({8'h06});
      xfer({8'h01, st});
      wait_idle;
      chk("status", {st[7:2], 2'b00}, status_word);
      xfer({8'h05, 8'h00});
      chk("status on link", {st[7:2], 2'b00}, sfp_hst_inst.rx);
      n = n_req;
      xfer({8'h06});
      xfer({8'h20, 8'(a[16]), a[15:8], a[7:0]});
      wait_idle;
      chk("erase taken", 19'(!prot(st[6:2], a)), 19'(n_req - n));
      chk("wel after erase", 0, status_word[1]);
      if (n_req != n)
        chk("erase target", {OP_SECT, a}, array_cmd);
    end
    // line one carries bits 7,5,3,1 of bytes 6E and 6F from the array model
    xfer({8'h3B, 8'h00, 8'h12, 8'h34, 8'h00, 8'h00});
    chk("dual read", 8'h77, sfp_hst_inst.rx);
    sfp_hst_inst.start;
    sfp_hst_inst.byte_x(8'h05);
    sfp_hst_inst.bit_x(1'b0);
    chk("reply driven", 1, e1);
    sfp_hst_inst.line_three = 1'b0; // clock low here
    repeat (8) @(posedge clk);
    chk("float in pause", 0, e1);
    sfp_hst_inst.cs_n = 1'b1;
    #100 sfp_hst_inst.line_three = 1'b1;
    #100 sfp_hst_inst.sclk = 1'b1; // mode 3 idle level
    #100 xfer({8'h05, 8'h00});
    chk("after abort", {st[7:2], 2'b00}, sfp_hst_inst.rx);
    xfer({8'h06});
    xfer({8'h01, 8'h80});
    wait_idle;
    sfp_hst_inst.line_two = 1'b0;
    xfer({8'h06});
    xfer({8'h01, 8'h00});
    chk("status locked", 16'h0082, status_word);
    final_report;
  end
endmodule
